// ---- logic/pbl_pkg.sv ----
// constants, timings and register map of the pushbutton power latch
package pbl_pkg;

  // clock and internal timebase
  localparam int CLK_HZ = 40_000_000;
  localparam int T_TICK_US = 100;
  localparam int TICK_CYC = T_TICK_US * (CLK_HZ / 1_000_000);
  localparam int TICK_W = 16;

  // documented durations in their own units
  localparam int T_GLITCH_US = 600;
  localparam int T_DB_SHORT_MS = 50;
  localparam int T_DB_LONG_MS = 2000;
  localparam int T_SD_SHORT_MS = 8000;
  localparam int T_SD_LONG_MS = 16000;
  localparam int T_INT_NOM_MS = 32;
  localparam int T_INT_EXT_MS = 128;
  localparam int BLANK_MULT = 2;

  // durations as timebase ticks
  localparam int CW = 18;
  typedef logic [CW-1:0] pbl_cnt_t;
  localparam pbl_cnt_t GLITCH_TICKS = pbl_cnt_t'((T_GLITCH_US + T_TICK_US - 1) / T_TICK_US);
  localparam pbl_cnt_t DB_SHORT_TICKS = pbl_cnt_t'(T_DB_SHORT_MS * 1000 / T_TICK_US);
  localparam pbl_cnt_t DB_LONG_TICKS = pbl_cnt_t'(T_DB_LONG_MS * 1000 / T_TICK_US);
  localparam pbl_cnt_t SD_SHORT_TICKS = pbl_cnt_t'(T_SD_SHORT_MS * 1000 / T_TICK_US);
  localparam pbl_cnt_t SD_LONG_TICKS = pbl_cnt_t'(T_SD_LONG_MS * 1000 / T_TICK_US);
  localparam pbl_cnt_t INT_NOM_TICKS = pbl_cnt_t'(T_INT_NOM_MS * 1000 / T_TICK_US);
  localparam pbl_cnt_t INT_EXT_TICKS = pbl_cnt_t'(T_INT_EXT_MS * 1000 / T_TICK_US);
  localparam pbl_cnt_t BLANK_TICKS = pbl_cnt_t'(BLANK_MULT * T_INT_NOM_MS * 1000 / T_TICK_US);

  // register byte offsets
  localparam int AW = 8;
  localparam logic [AW-1:0] ADR_CTRL = 8'h00;
  localparam logic [AW-1:0] ADR_STATUS = 8'h04;
  localparam logic [AW-1:0] ADR_IRQ_STAT = 8'h08;
  localparam logic [AW-1:0] ADR_IRQ_MASK = 8'h0c;

  // control fields
  localparam int CTRL_W = 2;
  localparam int CTRL_DB_LONG = 0;
  localparam int CTRL_SD_LONG = 1;
  localparam logic [CTRL_W-1:0] CTRL_RST = 2'h0;

  // status fields
  localparam int ST_POWER = 0;
  localparam int ST_INT = 1;
  localparam int ST_PRESSED = 2;
  localparam int ST_BLANK = 3;

  // interrupt fields
  localparam int IRQ_W = 3;
  localparam int IRQ_PRESS = 0;
  localparam int IRQ_LONG = 1;
  localparam int IRQ_CLEAR = 2;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

  typedef enum logic [1:0] {
    PBL_IDLE,
    PBL_DEBOUNCE,
    PBL_HELD,
    PBL_DONE
  } pbl_state_e;

endpackage

// ---- logic/pbl_top.sv ----
// pushbutton power latch with debouncer, interrupt pulse and wishbone registers
`timescale 1ns/1ps
module pbl_top #(
  parameter int TICK_CYC = pbl_pkg::TICK_CYC,
  parameter bit OFF_ON_LONG = 1'b1
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [pbl_pkg::AW-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // pins
  input wire logic button_in_n_i,
  input wire logic latch_clear_n_i,
  output logic power_o,
  output logic int_n_o,
  output logic int_oe_o,
  output logic irq_o
);

  // timebase
  logic [pbl_pkg::TICK_W-1:0] tick_cnt_r;
  logic [pbl_pkg::TICK_W-1:0] tick_cnt_nxt;
  logic tick_r;
  logic tick_nxt;

  // debouncer
  pbl_pkg::pbl_state_e state_r;
  pbl_pkg::pbl_state_e state_nxt;
  pbl_pkg::pbl_cnt_t press_cnt_r;
  pbl_pkg::pbl_cnt_t press_cnt_nxt;
  pbl_pkg::pbl_cnt_t rel_cnt_r;
  pbl_pkg::pbl_cnt_t rel_cnt_nxt;
  pbl_pkg::pbl_cnt_t db_ticks;
  pbl_pkg::pbl_cnt_t sd_ticks;
  logic ev_press;
  logic ev_long;
  logic pressed;

  // latch and pulse
  logic power_r;
  logic power_nxt;
  pbl_pkg::pbl_cnt_t int_cnt_r;
  pbl_pkg::pbl_cnt_t int_cnt_nxt;
  pbl_pkg::pbl_cnt_t blank_cnt_r;
  pbl_pkg::pbl_cnt_t blank_cnt_nxt;
  logic int_oe_r;
  logic int_oe_nxt;
  logic ev_clear;

  // registers
  logic [pbl_pkg::CTRL_W-1:0] ctrl_r;
  logic [pbl_pkg::CTRL_W-1:0] ctrl_nxt;
  logic [pbl_pkg::IRQ_W-1:0] irq_stat_r;
  logic [pbl_pkg::IRQ_W-1:0] irq_stat_nxt;
  logic [pbl_pkg::IRQ_W-1:0] irq_mask_r;
  logic [pbl_pkg::IRQ_W-1:0] irq_mask_nxt;
  logic irq_r;
  logic irq_nxt;
  logic ack_r;
  logic ack_nxt;
  logic [31:0] dat_r;
  logic [31:0] dat_nxt;
  logic wr_en;
  logic [pbl_pkg::IRQ_W-1:0] irq_set;

  always_comb begin
    tick_nxt = (tick_cnt_r == pbl_pkg::TICK_W'(TICK_CYC - 1));
    tick_cnt_nxt = tick_nxt ? '0 : tick_cnt_r + 1'b1;
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tick_cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  always_comb begin
    db_ticks = ctrl_r[pbl_pkg::CTRL_DB_LONG] ? pbl_pkg::DB_LONG_TICKS : pbl_pkg::DB_SHORT_TICKS;
    sd_ticks = ctrl_r[pbl_pkg::CTRL_SD_LONG] ? pbl_pkg::SD_LONG_TICKS : pbl_pkg::SD_SHORT_TICKS;
  end

  // debounce state machine
  always_comb begin
    state_nxt = state_r;
    press_cnt_nxt = press_cnt_r;
    rel_cnt_nxt = rel_cnt_r;
    ev_press = 1'b0;
    ev_long = 1'b0;
    case (state_r)
      pbl_pkg::PBL_IDLE: begin
        press_cnt_nxt = '0;
        rel_cnt_nxt = '0;
        if (!button_in_n_i) begin
          state_nxt = pbl_pkg::PBL_DEBOUNCE;
        end
      end
      pbl_pkg::PBL_DEBOUNCE, pbl_pkg::PBL_HELD, pbl_pkg::PBL_DONE: begin
        if (tick_r && state_r != pbl_pkg::PBL_DONE) begin
          press_cnt_nxt = press_cnt_r + 1'b1;
        end
        if (!button_in_n_i) begin
          rel_cnt_nxt = '0;
        end else if (tick_r) begin
          rel_cnt_nxt = rel_cnt_r + 1'b1;
        end
        if (rel_cnt_r >= pbl_pkg::GLITCH_TICKS) begin
          state_nxt = pbl_pkg::PBL_IDLE;
        end else if (state_r == pbl_pkg::PBL_DEBOUNCE && press_cnt_r >= db_ticks) begin
          state_nxt = pbl_pkg::PBL_HELD;
          ev_press = 1'b1;
        end else if (state_r == pbl_pkg::PBL_HELD && press_cnt_r >= sd_ticks) begin
          state_nxt = pbl_pkg::PBL_DONE;
          ev_long = 1'b1;
        end
      end
      default: begin
        state_nxt = pbl_pkg::PBL_IDLE;
      end
    endcase
    pressed = (state_r != pbl_pkg::PBL_IDLE);
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r <= pbl_pkg::PBL_IDLE;
      press_cnt_r <= '0;
      rel_cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      press_cnt_r <= press_cnt_nxt;
      rel_cnt_r <= rel_cnt_nxt;
    end
  end

  // latch, blanking and interrupt pulse
  always_comb begin
    power_nxt = power_r;
    int_cnt_nxt = int_cnt_r;
    blank_cnt_nxt = blank_cnt_r;
    ev_clear = 1'b0;
    if (tick_r && int_cnt_r != '0) begin
      int_cnt_nxt = int_cnt_r - 1'b1;
    end
    if (tick_r && blank_cnt_r != '0) begin
      blank_cnt_nxt = blank_cnt_r - 1'b1;
    end
    if (power_r && blank_cnt_r == '0 && !latch_clear_n_i) begin
      power_nxt = 1'b0;
      ev_clear = 1'b1;
    end
    if (ev_press) begin
      power_nxt = 1'b1;
      int_cnt_nxt = pbl_pkg::INT_NOM_TICKS;
      if (!power_r) begin
        blank_cnt_nxt = pbl_pkg::BLANK_TICKS;
      end
    end
    if (ev_long) begin
      int_cnt_nxt = pbl_pkg::INT_EXT_TICKS;
      if (OFF_ON_LONG) begin
        power_nxt = 1'b0;
      end
    end
    int_oe_nxt = (int_cnt_nxt != '0);
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      power_r <= 1'b0;
      int_cnt_r <= '0;
      blank_cnt_r <= '0;
      int_oe_r <= 1'b0;
    end else begin
      power_r <= power_nxt;
      int_cnt_r <= int_cnt_nxt;
      blank_cnt_r <= blank_cnt_nxt;
      int_oe_r <= int_oe_nxt;
    end
  end

  // wishbone slave and interrupt registers
  always_comb begin
    ack_nxt = wb_cyc_i && wb_stb_i && !ack_r;
    wr_en = ack_nxt && wb_we_i && wb_sel_i[0];
    ctrl_nxt = ctrl_r;
    irq_mask_nxt = irq_mask_r;
    irq_set = '0;
    irq_set[pbl_pkg::IRQ_PRESS] = ev_press;
    irq_set[pbl_pkg::IRQ_LONG] = ev_long;
    irq_set[pbl_pkg::IRQ_CLEAR] = ev_clear;
    irq_stat_nxt = irq_stat_r;
    if (wr_en && wb_adr_i == pbl_pkg::ADR_CTRL) begin
      ctrl_nxt = wb_dat_i[pbl_pkg::CTRL_W-1:0];
    end
    if (wr_en && wb_adr_i == pbl_pkg::ADR_IRQ_MASK) begin
      irq_mask_nxt = wb_dat_i[pbl_pkg::IRQ_W-1:0];
    end
    if (wr_en && wb_adr_i == pbl_pkg::ADR_IRQ_STAT) begin
      irq_stat_nxt = irq_stat_r & ~wb_dat_i[pbl_pkg::IRQ_W-1:0];
    end
    // set wins over clear
    irq_stat_nxt = irq_stat_nxt | irq_set;
    irq_nxt = |(irq_stat_nxt & irq_mask_nxt);
    dat_nxt = '0;
    if (ack_nxt && !wb_we_i) begin
      case (wb_adr_i)
        pbl_pkg::ADR_CTRL: begin
          dat_nxt[pbl_pkg::CTRL_W-1:0] = ctrl_r;
        end
        pbl_pkg::ADR_STATUS: begin
          dat_nxt[pbl_pkg::ST_POWER] = power_r;
          dat_nxt[pbl_pkg::ST_INT] = int_oe_r;
          dat_nxt[pbl_pkg::ST_PRESSED] = pressed;
          dat_nxt[pbl_pkg::ST_BLANK] = (blank_cnt_r != '0);
        end
        pbl_pkg::ADR_IRQ_STAT: begin
          dat_nxt[pbl_pkg::IRQ_W-1:0] = irq_stat_r;
        end
        pbl_pkg::ADR_IRQ_MASK: begin
          dat_nxt[pbl_pkg::IRQ_W-1:0] = irq_mask_r;
        end
        default: begin
          dat_nxt = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_r <= pbl_pkg::CTRL_RST;
      irq_mask_r <= pbl_pkg::IRQ_MASK_RST;
      irq_stat_r <= '0;
      irq_r <= 1'b0;
      ack_r <= 1'b0;
      dat_r <= '0;
    end else begin
      ctrl_r <= ctrl_nxt;
      irq_mask_r <= irq_mask_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq_r <= irq_nxt;
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
    end
  end

  // output drive
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      int_n_o <= 1'b0;
    end else begin
      int_n_o <= 1'b0;
    end
  end

  assign power_o = power_r;
  assign int_oe_o = int_oe_r;
  assign irq_o = irq_r;
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

endmodule

// ---- tb/pbl_properties.sv ----
// assertion checker for the pushbutton power latch
`timescale 1ns/1ps
module pbl_checker #(
  parameter int TICK_CYC = 4,
  parameter bit OFF_ON_LONG = 1'b1
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic button_in_n_i,
  input wire logic latch_clear_n_i,
  input wire logic power_o,
  input wire logic int_n_o,
  input wire logic int_oe_o
);
  int hi_cnt;
  int on_cnt;
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hi_cnt <= 0;
      on_cnt <= 0;
    end else begin
      hi_cnt <= int_oe_o ? hi_cnt + 1 : 0;
      on_cnt <= power_o ? on_cnt + 1 : 0;
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  a_int_data_low: assert property (int_n_o == 1'b0)
    else $error("int data bit not low");
  a_on_with_pulse: assert property ($rose(power_o) |-> $rose(int_oe_o))
    else $error("power rose without pulse");
  a_pulse_min_len: assert property ($fell(int_oe_o) |-> hi_cnt >= 319 * TICK_CYC - 1)
    else $error("pulse too short");
  a_pulse_max_len: assert property (int_oe_o |-> hi_cnt <= 1281 * TICK_CYC + 2)
    else $error("pulse too long");
  a_blank_hold: assert property (power_o && on_cnt < 639 * TICK_CYC |=> power_o)
    else $error("cleared during blanking");
  a_clear_acts: assert property (power_o && on_cnt > 642 * TICK_CYC && !latch_clear_n_i && button_in_n_i
    |-> ##[1:3] !power_o)
    else $error("clear not obeyed");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack");
  a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  c_power_on: cover property ($rose(power_o));
  c_clear_off: cover property ($fell(power_o) && !latch_clear_n_i);
  c_pulse_end: cover property ($fell(int_oe_o));
  c_long_off: cover property ($fell(power_o) && $rose(int_oe_o));
endmodule
bind pbl_top pbl_checker #(.TICK_CYC(TICK_CYC), .OFF_ON_LONG(OFF_ON_LONG)) u_chk (.clock_i(clock_i),
  .arst_n_i(arst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
  .button_in_n_i(button_in_n_i), .latch_clear_n_i(latch_clear_n_i), .power_o(power_o),
  .int_n_o(int_n_o), .int_oe_o(int_oe_o));

// ---- tb/pbl_switch_model.sv ----
// pushbutton and system clear driver
`timescale 1ns/1ps
module pbl_switch_model (
  // clock
  input wire logic clock_i,
  // pins
  output logic button_in_n_o,
  output logic latch_clear_n_o
);
  initial begin
    button_in_n_o = 1'b1;
    latch_clear_n_o = 1'b1;
  end
  // closure of n cycles, bounce of g cycles every 200
  task automatic press(input int n, input int g);
    for (int i = 0; i < n; i++) begin
      @(posedge clock_i);
      button_in_n_o <= (g > 0 && i % 200 >= 200 - g);
    end
    @(posedge clock_i);
    button_in_n_o <= 1'b1;
  endtask
  task automatic clear(input logic lvl);
    @(posedge clock_i);
    latch_clear_n_o <= lvl;
  endtask
endmodule

// ---- tb/tb_top.sv ----
// self-checking bench for the pushbutton power latch
`timescale 1ns/1ps
module tb_top;
  localparam int TC = 1;
  logic clock_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, button_n, clear_n, power_o, int_n_o, int_oe_o, irq_o;
  logic [31:0] rng = 32'h5d;
  logic [31:0] rd;
  int errors = 0;
  int n_compared = 0;
  int cyc = 0;
  int t0 = 0;
  logic exp_power = 1'b0;
  always #12.5 clock_i = ~clock_i;
  pbl_top #(.TICK_CYC(TC), .OFF_ON_LONG(1'b1)) dut (.clock_i(clock_i), .arst_n_i(arst_n_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .button_in_n_i(button_n),
    .latch_clear_n_i(clear_n), .power_o(power_o), .int_n_o(int_n_o), .int_oe_o(int_oe_o), .irq_o(irq_o));
  pbl_switch_model sw (.clock_i(clock_i), .button_in_n_o(button_n), .latch_clear_n_o(clear_n));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic check(input string name, input logic [31:0] e, input logic [31:0] got);
    n_compared++;
    if (got !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, e, got);
    end
  endtask
  task automatic finish_test();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      errors++;
      finish_test();
    end
  end
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clock_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string n);
    wb(1'b0, a, 32'h0);
    check(n, e, rd);
  endtask
  task automatic wait_pulse(input int lim);
    int k;
    k = 0;
    while (int_oe_o !== 1'b1 && k < lim) begin
      @(posedge clock_i);
      k++;
    end
    t0 = cyc;
  endtask
  task automatic press_on(input int g);
    fork
      sw.press(575 * TC, g);
    join_none
    repeat (475 * TC) @(posedge clock_i);
    check("power_early", exp_power, power_o);
    wait_pulse(100 * TC);
    exp_power = 1'b1;
    check("power_on", exp_power, power_o);
  endtask
  initial begin
    repeat (4) @(posedge clock_i);
    arst_n_i <= 1'b1;
    rdchk(8'h00, 32'h0, "ctrl");
    rdchk(8'h0c, 32'h0, "mask");
    rng = xs(rng);
    wb(1'b1, 8'h40, rng);
    rdchk(8'h40, 32'h0, "unmapped");
    wb(1'b1, 8'h0c, 32'h1);
    rdchk(8'h0c, 32'h1, "mask");
    rng = xs(rng);
    press_on(TC * (1 + int'(rng[1:0])));
    repeat (318 * TC) @(posedge clock_i);
    check("pulse_mid", 1'b1, int_oe_o);
    repeat (4 * TC) @(posedge clock_i);
    check("pulse_end", 1'b0, int_oe_o);
    check("irq", 1'b1, irq_o);
    rdchk(8'h08, 32'h1, "stat");
    sw.clear(1'b0);
    while (cyc - t0 < 630 * TC) @(posedge clock_i);
    check("blank", exp_power, power_o);
    while (cyc - t0 < 650 * TC) @(posedge clock_i);
    exp_power = 1'b0;
    check("cleared", exp_power, power_o);
    wb(1'b1, 8'h08, 32'h1);
    check("irq_masked", 1'b0, irq_o);
    rdchk(8'h08, 32'h4, "stat_clr");
    wb(1'b1, 8'h08, 32'h7);
    sw.press(300 * TC, 0);
    repeat (10 * TC) @(posedge clock_i);
    sw.press(300 * TC, 0);
    check("no_event", exp_power, power_o);
    check("no_pulse", 1'b0, int_oe_o);
    repeat (10 * TC) @(posedge clock_i);
    press_on(0);
    sw.clear(1'b1);
    repeat (350 * TC) @(posedge clock_i);
    sw.press(550 * TC, 0);
    check("stay_on", exp_power, power_o);
    check("pulse_again", 1'b1, int_oe_o);
    rdchk(8'h08, 32'h1, "stat_again");
    sw.clear(1'b0);
    repeat (4) @(posedge clock_i);
    exp_power = 1'b0;
    check("clear_late", exp_power, power_o);
    sw.clear(1'b1);
    wb(1'b1, 8'h08, 32'h7);
    fork
      sw.press(81600 * TC, 0);
    join_none
    repeat (79900 * TC) @(posedge clock_i);
    exp_power = 1'b1;
    check("long_before", exp_power, power_o);
    check("long_idle", 1'b0, int_oe_o);
    wait_pulse(200 * TC);
    exp_power = 1'b0;
    check("long_off", exp_power, power_o);
    repeat (1270 * TC) @(posedge clock_i);
    check("ext_mid", 1'b1, int_oe_o);
    repeat (20 * TC) @(posedge clock_i);
    check("ext_end", 1'b0, int_oe_o);
    repeat (300 * TC) @(posedge clock_i);
    check("no_repulse", 1'b0, int_oe_o);
    check("still_off", exp_power, power_o);
    rdchk(8'h08, 32'h3, "stat_long");
    finish_test();
  end
endmodule
